// ==== test_twm_dma_tx_regs.sv ====
`timescale 1ns/100ps
// ****
// bench for the two-wire master register block
// ****
module test_twm_dma_tx_regs;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, mem_rd_req, mem_rd_valid;
  logic        rx_list_mode, busy, irq, scl_i, scl_o, scl_oe;
  logic        sda_i, sda_o, sda_oe, s_scl, s_sda, slow;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rd_addr, got;
  logic [7:0]  mem_rd_data, nack_at;
  int          err_count, num_checks;

  // open-drain lines: high unless a party pulls them low
  assign scl_i = ~(scl_oe | s_scl);
  assign sda_i = ~(sda_oe | s_sda);
  twm_dma_tx_regs DUT (.*);
  twm_slave_model u_slave (.scl(scl_i), .sda(sda_i), .nack_at(nack_at),
    .slow(slow), .sda_pull(s_sda), .scl_pull(s_scl), .got(got));

  // memory answers a cycle late; its data bus churns in between
  always @(posedge clk_sys) begin
    mem_rd_valid <= mem_rd_req;
    mem_rd_data <= mem_rd_req ? mem_rd_addr[7:0] ^ 8'h5A : ~mem_rd_data;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] exp, string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask : rd

  // start, poke mid-flight (count reads, refused task), wait for the end
  task automatic run(logic [31:0] t, logic [31:0] prev);
    wr(12'h600, t);
    rd(12'h54C, prev, "amount in flight");
    rd(12'h54C, prev, "amount in flight");
    wr(12'h600, t);
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(negedge clk_sys);
    repeat (4) @(negedge clk_sys);
    chk("idle", 32'h0000_0000, {31'h0, busy});
  endtask : run

  task automatic t_reset();
    logic [11:0] ofs [6] = '{12'h540, 12'h544, 12'h548, 12'h54C, 12'h550,
                             12'h588};
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000, "reset");
    chk("rx pin", 32'h0000_0000, {31'h0, rx_list_mode});
  endtask : t_reset

  task automatic t_regs();
    wr(12'h540, 32'h0000_0001);
    rd(12'h540, 32'h0000_0001, "rx list");
    chk("rx pin", 32'h0000_0001, {31'h0, rx_list_mode});
    wr(12'h540, 32'h0000_0000);
    rd(12'h540, 32'h0000_0000, "rx list");
    wr(12'h550, 32'h0000_0001);
    rd(12'h550, 32'h0000_0001, "tx list");
    wr(12'h54C, 32'h0000_FFFF);
    rd(12'h54C, 32'h0000_0000, "amount ro");
    rd(12'h7FC, 32'h0000_0000, "unmapped");
    wr(12'h544, 32'hFFFF_FFF0);
    rd(12'h544, 32'hFFFF_FFF0, "pointer");
  endtask : t_regs

  // array list on: pointer steps by the max count afterwards
  task automatic t_tx_list();
    wr(12'h544, 32'h0000_0100);
    wr(12'h548, 32'h0000_0002);
    wr(12'h588, 32'h0000_0055);
    wr(12'h608, 32'h0000_0001);
    run(32'h0000_0002, 32'h0000_0000);
    chk("bytes", 32'h00AA_5A5B, {8'h00, got[23:0]});
    rd(12'h54C, 32'h0000_0002, "amount");
    rd(12'h544, 32'h0000_0102, "list step");
    rd(12'h604, 32'h0000_0001, "events");
    chk("irq", 32'h0000_0001, {31'h0, irq});
  endtask : t_tx_list

  // slow slave refuses the second data byte; both tasks at once
  task automatic t_tx_nack();
    wr(12'h550, 32'h0000_0000);
    wr(12'h544, 32'h0000_0230);
    wr(12'h548, 32'h0000_0003);
    {nack_at, slow} <= {8'h02, 1'b1};
    run(32'h0000_0003, 32'h0000_0002);
    chk("bytes", 32'h00AA_6A6B, {8'h00, got[23:0]});
    rd(12'h54C, 32'h0000_0002, "amount nack");
    rd(12'h544, 32'h0000_0230, "no step");
    rd(12'h604, 32'h0000_0003, "events");
    wr(12'h608, 32'h0000_0002);
    wr(12'h604, 32'h0000_0002);
    rd(12'h604, 32'h0000_0001, "nack cleared");
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(12'h604, 32'h0000_0001);
    rd(12'h604, 32'h0000_0000, "events clear");
  endtask : t_tx_nack

  task automatic t_rx();
    wr(12'h588, 32'h0000_002A);
    {nack_at, slow} <= {8'hFF, 1'b0};
    run(32'h0000_0001, 32'h0000_0002);
    chk("rx addr", 32'h0000_0055, {24'h0, got[7:0]});
  endtask : t_rx

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // the three transfers need about 70000 cycles
  initial begin
    #900000;
    err_count++;
    stop_test();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 46'h0};
    {mem_rd_valid, mem_rd_data, nack_at, slow} = {9'h0, 8'hFF, 1'b0};
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_tx_list();
    t_tx_nack();
    t_rx();
    stop_test();
  end
endmodule : test_twm_dma_tx_regs

// ==== twm_bit_engine.sv ====
`timescale 1ns/100ps
`include "twm_params.svh"

module twm_bit_engine (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             cmd_valid,
  input  wire twm_pkg::twm_cmd_t cmd_kind,
  input  wire logic [7:0]       cmd_byte,
  output logic                  done,
  output logic                  nack,
  input  wire logic             scl_i,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_oe
);

  localparam logic [8:0] QTR_M1 = 9'(`TWM_QTR_CYC - 1);

  twm_pkg::twm_eng_st_t q;
  twm_pkg::twm_eng_st_t d;

  // ****************************************************************
  // quarter-bit sequencing of scl and sda
  // ****************************************************************
  // pins are open drain: oe high pulls the line low
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.scl_sy = {q.scl_sy[0], scl_i};
    d.sda_sy = {q.sda_sy[0], sda_i};
    if (!q.busy) begin
      if (cmd_valid) begin
        d.busy = 1'b1;
        d.kind = cmd_kind;
        d.sh   = cmd_byte;
        d.bitc = 4'h0;
        d.ph   = 2'h0;
        d.div  = QTR_M1;
      end
    end else if (q.div != 9'h000) begin
      d.div = q.div - 9'h001;
    end else if (q.ph == 2'h2 && !q.scl_sy[1]) begin
      // slave stretches the clock: hold until scl is seen high
      d.div = 9'h000;
    end else begin
      d.div = QTR_M1;
      d.ph  = q.ph + 2'h1;
      case (q.kind)
        twm_pkg::CMD_START: begin
          case (q.ph)
            2'h0: begin
              d.sda_oe = 1'b0;
              d.scl_oe = 1'b0;
            end
            2'h1: d.sda_oe = 1'b1;   // sda falls while scl high
            default: begin
              d.scl_oe = 1'b1;
              d.busy   = 1'b0;
              d.done   = 1'b1;
            end
          endcase
        end
        twm_pkg::CMD_BYTE: begin
          case (q.ph)
            2'h0: begin
              d.scl_oe = 1'b1;
              d.sda_oe = (q.bitc == 4'h8) ? 1'b0 : ~q.sh[7];
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitc == 4'h8) begin
                d.nack = q.sda_sy[1];       // high at ack slot is refusal
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.sh     = {q.sh[6:0], 1'b0};
              if (q.bitc == 4'h8) begin
                d.busy = 1'b0;
                d.done = 1'b1;
              end else begin
                d.bitc = q.bitc + 4'h1;
              end
            end
          endcase
        end
        default: begin
          case (q.ph)
            2'h0: begin
              d.scl_oe = 1'b1;
              d.sda_oe = 1'b1;
            end
            2'h1: d.scl_oe = 1'b0;
            default: begin
              d.sda_oe = 1'b0;   // sda rises while scl high
              d.busy   = 1'b0;
              d.done   = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done   = q.done;
  assign nack   = q.nack;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;

endmodule : twm_bit_engine

// ==== twm_dma_tx_regs.sv ====
`timescale 1ns/100ps
`include "twm_params.svh"

// Operation
// - receive list mode 0 plain buffer, 1 array list; resets to 0
// - transmit list mode 0 plain buffer, 1 array list; resets to 0
// - no more than the maximum count bytes are sent per transaction
// - read-only 16-bit transferred count, includes a refused byte
// - the address register supplies the slave address of each transfer
// - bus activity starts about 6.5 us after a start task: a 1.5 us delay, then two quarter bits before sda falls
// - data refused by the slave sets a flag, cleared by writing one
module twm_dma_tx_regs (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             mem_rd_req,
  output logic      [31:0] mem_rd_addr,
  input  wire logic  [7:0] mem_rd_data,
  input  wire logic        mem_rd_valid,
  output logic             rx_list_mode,
  output logic             busy,
  output logic             irq,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  localparam logic [7:0] START_M1 = 8'(`TWM_START_CYC - 1);

  twm_pkg::twm_top_st_t q;
  twm_pkg::twm_top_st_t d;

  logic eng_done;
  logic eng_nack;
  logic eng_scl_oe;
  logic eng_sda_oe;
  logic wr_task;
  logic wr_evt;

  // ****************************************************************
  // two-wire bit engine
  // ****************************************************************
  twm_bit_engine u_eng (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .cmd_valid (q.cmd_valid),
    .cmd_kind  (q.cmd_kind),
    .cmd_byte  (q.cmd_byte),
    .done      (eng_done),
    .nack      (eng_nack),
    .scl_i     (scl_i),
    .scl_oe    (eng_scl_oe),
    .sda_i     (sda_i),
    .sda_oe    (eng_sda_oe)
  );

  // strobes decoded once for the register process
  assign wr_task = reg_wr && (reg_addr == `TWM_OFS_TASKS);
  assign wr_evt  = reg_wr && (reg_addr == `TWM_OFS_EVENTS);

  // ****************************************************************
  // registers, events and transaction sequencer
  // ****************************************************************
  always_comb begin
    d           = q;
    d.cmd_valid = 1'b0;
    d.mem_req   = 1'b0;

    // software writes; writes to the read-only count are dropped
    if (reg_wr) begin
      case (reg_addr)
        `TWM_OFS_RX_LIST:  d.rx_list    = reg_wdata[0];
        `TWM_OFS_TX_LIST:  d.tx_list    = reg_wdata[0];
        `TWM_OFS_TX_PTR:   d.tx_ptr     = reg_wdata;
        `TWM_OFS_TX_MAXCNT: d.tx_maxcnt = reg_wdata;
        `TWM_OFS_ADDRESS:  d.slave_addr = reg_wdata[6:0];
        `TWM_OFS_INTMASK:  d.mask       = reg_wdata[2:0];
        default: ;
      endcase
    end

    // write one to clear; a set in the same cycle wins below
    if (wr_evt) begin
      d.evt = q.evt & ~reg_wdata[2:0];
    end

    // read data stands in the cycle after the strobe only
    d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `TWM_OFS_RX_LIST:   d.rdata = {31'h0, q.rx_list};
        `TWM_OFS_TX_PTR:    d.rdata = q.tx_ptr;
        `TWM_OFS_TX_MAXCNT: d.rdata = q.tx_maxcnt;
        `TWM_OFS_TX_AMOUNT: d.rdata = {16'h0000, q.tx_amount};
        `TWM_OFS_TX_LIST:   d.rdata = {31'h0, q.tx_list};
        `TWM_OFS_ADDRESS:   d.rdata = {25'h0, q.slave_addr};
        `TWM_OFS_EVENTS:    d.rdata = {29'h0, q.evt};
        `TWM_OFS_INTMASK:   d.rdata = {29'h0, q.mask};
        default:            d.rdata = 32'h0000_0000;
      endcase
    end

    case (q.seq)
      twm_pkg::ST_IDLE: begin
        // tasks written while busy are ignored
        if (wr_task && (reg_wdata[`TWM_TASK_RX_BIT] ||
                        reg_wdata[`TWM_TASK_TX_BIT])) begin
          d.rnw     = ~reg_wdata[`TWM_TASK_TX_BIT];
          d.cur_ptr = q.tx_ptr;
          d.cnt     = 16'h0000;
          d.dly     = START_M1;
          d.busy    = 1'b1;
          d.seq     = twm_pkg::ST_DLY;
        end
      end
      twm_pkg::ST_DLY: begin
        // fixed start latency before the start condition
        if (q.dly == 8'h00) begin
          d.seq    = twm_pkg::ST_START;
          d.issued = 1'b0;
        end else begin
          d.dly = q.dly - 8'h01;
        end
      end
      twm_pkg::ST_START: begin
        if (!q.issued) begin
          d.cmd_valid = 1'b1;
          d.cmd_kind  = twm_pkg::CMD_START;
          d.issued    = 1'b1;
        end else if (eng_done) begin
          d.seq    = twm_pkg::ST_ADDR;
          d.issued = 1'b0;
        end
      end
      twm_pkg::ST_ADDR: begin
        if (!q.issued) begin
          d.cmd_valid = 1'b1;
          d.cmd_kind  = twm_pkg::CMD_BYTE;
          d.cmd_byte  = {q.slave_addr, q.rnw};
          d.issued    = 1'b1;
        end else if (eng_done) begin
          d.issued = 1'b0;
          if (eng_nack) begin
            d.evt[`TWM_EVT_ANACK] = 1'b1;
            d.seq = twm_pkg::ST_STOP;
          end else if (q.rnw) begin
            // receive data path lives outside this block
            d.seq = twm_pkg::ST_STOP;
          end else begin
            d.seq = twm_pkg::ST_FETCH;
          end
        end
      end
      twm_pkg::ST_FETCH: begin
        // stop once the maximum count has gone out
        if ({16'h0000, q.cnt} >= q.tx_maxcnt) begin
          d.seq    = twm_pkg::ST_STOP;
          d.issued = 1'b0;
        end else if (!q.issued) begin
          d.mem_req  = 1'b1;
          d.mem_addr = q.cur_ptr;
          d.issued   = 1'b1;
        end else if (mem_rd_valid) begin
          d.cmd_byte = mem_rd_data;
          d.cur_ptr  = q.cur_ptr + 32'h0000_0001;
          d.issued   = 1'b0;
          d.seq      = twm_pkg::ST_DATA;
        end
      end
      twm_pkg::ST_DATA: begin
        if (!q.issued) begin
          d.cmd_valid = 1'b1;
          d.cmd_kind  = twm_pkg::CMD_BYTE;
          d.issued    = 1'b1;
        end else if (eng_done) begin
          // the refused byte still counts as transferred
          d.cnt    = q.cnt + 16'h0001;
          d.issued = 1'b0;
          if (eng_nack) begin
            d.evt[`TWM_EVT_DATA_NACK_ERROR] = 1'b1;
            d.seq = twm_pkg::ST_STOP;
          end else begin
            d.seq = twm_pkg::ST_FETCH;
          end
        end
      end
      twm_pkg::ST_STOP: begin
        if (!q.issued) begin
          d.cmd_valid = 1'b1;
          d.cmd_kind  = twm_pkg::CMD_STOP;
          d.issued    = 1'b1;
        end else if (eng_done) begin
          // count moves only after stop, so software sees it settled
          d.tx_amount = q.cnt;
          d.evt[`TWM_EVT_STOPPED] = 1'b1;
          d.busy   = 1'b0;
          d.issued = 1'b0;
          d.seq    = twm_pkg::ST_IDLE;
          // array list steps the pointer to the next buffer slot
          // only a pointer write beats the step; other writes must not
          if (q.tx_list && !q.rnw &&
              !(reg_wr && reg_addr == `TWM_OFS_TX_PTR)) begin
            d.tx_ptr = q.tx_ptr + q.tx_maxcnt;
          end
        end
      end
      default: d.seq = twm_pkg::ST_IDLE;
    endcase

    d.irq = |(d.evt & d.mask);
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q     <= '0;
      q.seq <= twm_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs from flip-flops, except scl_o and sda_o tied low
  // ****************************************************************
  assign reg_rdata    = q.rdata;
  assign mem_rd_req   = q.mem_req;
  assign mem_rd_addr  = q.mem_addr;
  assign rx_list_mode = q.rx_list;
  assign busy         = q.busy;
  assign irq          = q.irq;
  assign scl_o        = 1'b0;  // open drain: only low is ever driven
  assign sda_o        = 1'b0;
  assign scl_oe       = eng_scl_oe;
  assign sda_oe       = eng_sda_oe;

endmodule : twm_dma_tx_regs

// ==== twm_dma_tx_regs_sva.sv ====
`timescale 1ns/100ps
// ****
// port checks of the two-wire master registers
// ****
module twm_dma_tx_regs_sva (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic        rx_list_mode,
  input wire logic        busy,
  input wire logic        scl_oe,
  input wire logic        sda_oe
);
  logic        amt_rd_q, amt_ok_q, seen_q, go_q, start_w;
  logic [31:0] amt_q, max_q, last_q, nreq_q;
  logic [9:0]  since_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a task write only counts while idle; busy ones are refused
  assign start_w = reg_wr && reg_addr == 12'h600 && |reg_wdata[1:0]
                   && !busy;
  // shadows of writes and fetches; the flags and fetch count clear between transfers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {amt_rd_q, amt_ok_q, seen_q, go_q, since_q} <= '0;
      {amt_q, max_q, last_q, nreq_q} <= '0;
    end else begin
      amt_rd_q <= reg_rd && reg_addr == 12'h54C;
      amt_ok_q <= busy && (amt_ok_q || amt_rd_q);
      if (amt_rd_q) amt_q <= reg_rdata;
      if (reg_wr && reg_addr == 12'h548) max_q <= reg_wdata;
      seen_q <= busy && (seen_q || mem_rd_req);
      if (mem_rd_req) last_q <= mem_rd_addr;
      nreq_q <= busy ? nreq_q + {31'h0, mem_rd_req} : '0;
      go_q <= (go_q || sda_oe) && !start_w;
      since_q <= start_w ? '0 : since_q + {9'h0, ~&since_q};  // saturates
    end
  end
  chk_rx_write: assert property (reg_wr && reg_addr == 12'h540
    |=> rx_list_mode == $past(reg_wdata[0])) else $error("rx list pin");
  chk_rx_read: assert property (reg_rd && reg_addr == 12'h540
    |=> reg_rdata == {31'h0, $past(rx_list_mode)}) else $error("rx read");
  chk_start_delay: assert property ($rose(sda_oe) && !go_q
    |-> since_q inside {[148:660]}) else $error("start delay");
  chk_idle_bus: assert property (!busy |-> !scl_oe && !sda_oe)
    else $error("bus driven while idle");
  chk_fetch_step: assert property (mem_rd_req && seen_q
    |-> mem_rd_addr == last_q + 32'h0000_0001) else $error("fetch order");
  chk_fetch_limit: assert property (mem_rd_req |-> nreq_q < max_q)
    else $error("fetch beyond max count");
  chk_amount_width: assert property (amt_rd_q
    |-> reg_rdata[31:16] == 16'h0000) else $error("amount width");
  chk_amount_hold: assert property (amt_rd_q && busy && amt_ok_q
    |-> reg_rdata == amt_q) else $error("amount moved in flight");
  cover property ($fell(busy));
  cover property (mem_rd_req && seen_q);
  cover property (amt_rd_q && amt_ok_q);
endmodule : twm_dma_tx_regs_sva

bind twm_dma_tx_regs twm_dma_tx_regs_sva u_sva (.*);

// ==== twm_params.svh ====
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TWM_OFS_RX_LIST     12'h540
`define TWM_OFS_TX_PTR      12'h544
`define TWM_OFS_TX_MAXCNT   12'h548
`define TWM_OFS_TX_AMOUNT   12'h54C
`define TWM_OFS_TX_LIST     12'h550
`define TWM_OFS_ADDRESS     12'h588
`define TWM_OFS_TASKS       12'h600
`define TWM_OFS_EVENTS      12'h604
`define TWM_OFS_INTMASK     12'h608

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define TWM_TASK_RX_BIT     0
`define TWM_TASK_TX_BIT     1
`define TWM_EVT_STOPPED     0
`define TWM_EVT_DATA_NACK_ERROR       1
`define TWM_EVT_ANACK       2
`define TWM_RST_ZERO        32'h0000_0000
`define TWM_AMOUNT_W        16

// ****************************************************************
// timing
// ****************************************************************
`define TWM_CLK_NS          10
`define TWM_T_START_NS      1500
`define TWM_START_CYC       (`TWM_T_START_NS / `TWM_CLK_NS)
`define TWM_T_QTR_NS        2500
`define TWM_QTR_CYC         (`TWM_T_QTR_NS / `TWM_CLK_NS)

`endif

// ==== twm_pkg.sv ====
package twm_pkg;

  // ****************************************************************
  // bit engine commands
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_START,
    CMD_BYTE,
    CMD_STOP
  } twm_cmd_t;

  // ****************************************************************
  // transaction sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DLY,
    ST_START,
    ST_ADDR,
    ST_FETCH,
    ST_DATA,
    ST_STOP
  } twm_seq_t;

  typedef struct packed {
    logic           busy;
    twm_cmd_t       kind;
    logic [3:0]     bitc;
    logic [1:0]     ph;
    logic [8:0]     div;
    logic [7:0]     sh;
    logic           scl_oe;
    logic           sda_oe;
    logic           done;
    logic           nack;
    logic [1:0]     scl_sy;
    logic [1:0]     sda_sy;
  } twm_eng_st_t;

  typedef struct packed {
    twm_seq_t       seq;
    logic           issued;
    logic [7:0]     dly;
    logic [15:0]    cnt;
    logic           rnw;
    logic [31:0]    cur_ptr;
    logic           rx_list;
    logic           tx_list;
    logic [31:0]    tx_ptr;
    logic [31:0]    tx_maxcnt;
    logic [15:0]    tx_amount;
    logic [6:0]     slave_addr;
    logic [2:0]     evt;
    logic [2:0]     mask;
    logic [31:0]    rdata;
    logic           irq;
    logic           cmd_valid;
    twm_cmd_t       cmd_kind;
    logic [7:0]     cmd_byte;
    logic           mem_req;
    logic [31:0]    mem_addr;
    logic           busy;
  } twm_top_st_t;

endpackage : twm_pkg

// ==== twm_slave_model.sv ====
`timescale 1ns/100ps
// ****
// two-wire slave: acks, refuses one byte, may stretch
// ****
module twm_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] nack_at,
  input  wire logic       slow,
  output logic            sda_pull,
  output logic            scl_pull,
  output logic     [31:0] got
);
  int         bits = 0;
  int         nb = 0;
  logic [7:0] sh;
  initial {sda_pull, scl_pull, got} = '0;
  // start condition rearms the byte counters
  always @(negedge sda) if (scl === 1'b1) {bits, nb} = '0;
  // msb first on the rising clock; the ninth clock is the ack
  always @(posedge scl) begin
    if (bits == 8) begin
      bits = 0;
      nb++;
    end else begin
      sh = {sh[6:0], sda};
      bits++;
      if (bits == 8) got = {got[23:0], sh};
    end
  end
  // pull low to ack; a refused byte leaves the line to the pull-up
  always @(negedge scl) begin
    sda_pull = (bits == 8) && (nb != int'(nack_at));
    if (bits == 8 && slow) begin
      scl_pull = 1'b1;  // slow device holds the clock low
      #8000 scl_pull = 1'b0;  // outlasts the master's own low phase
    end
  end
endmodule : twm_slave_model
